/* File: src/cfsl_map.vh */
// register map, field positions, reset values and timing constants
`ifndef CFSL_MAP_VH
`define CFSL_MAP_VH

// register byte offsets
`define CFSL_OFS_CTRL        8'h00
`define CFSL_OFS_SAMPLE_TIME 8'h04
`define CFSL_OFS_PRESET      8'h08
`define CFSL_OFS_COUNT       8'h0c
`define CFSL_OFS_LATCH1      8'h10
`define CFSL_OFS_LATCH2      8'h14
`define CFSL_OFS_SAMPLE_CNT  8'h18
`define CFSL_OFS_STATUS      8'h1c

// control register fields
`define CFSL_CTRL_COUNT_EN   0
`define CFSL_CTRL_START      1
`define CFSL_CTRL_NEG_LOGIC  2
`define CFSL_CTRL_FSEL_LO    4
`define CFSL_CTRL_FSEL_HI    6

// status register fields
`define CFSL_STAT_SAMPLING   0
`define CFSL_STAT_HOLD       1
`define CFSL_STAT_LATCH1_PND 2
`define CFSL_STAT_LATCH2_PND 3

// function select codes
`define CFSL_FN_LATCH        3'h0
`define CFSL_FN_DISABLE      3'h1
`define CFSL_FN_SAMPLE       3'h2
`define CFSL_FN_DIS_PRESET   3'h3
`define CFSL_FN_LATCH_PRESET 3'h4

// reset values
`define CFSL_RST_CTRL        32'h0000_0000
`define CFSL_RST_SAMPLE_TIME 16'h0001
`define CFSL_RST_PRESET      32'h0000_0000

// timing
`define CFSL_CLK_PERIOD_NS   100
`define CFSL_CTRL_CYCLE_MS   1
`define CFSL_TICK_CYCLES     ((`CFSL_CTRL_CYCLE_MS * 1000000) / `CFSL_CLK_PERIOD_NS)
`define CFSL_SAMPLE_UNIT_MS  10
`define CFSL_SAMPLE_UNIT_TICKS (`CFSL_SAMPLE_UNIT_MS / `CFSL_CTRL_CYCLE_MS)

`endif

/* File: src/cfsl_edge_sampler.v */
// optional synchroniser, polarity and control-cycle edge sampler
`timescale 1ns/10ps
`default_nettype none

module cfsl_edge_sampler #(
    parameter SYNC = 1
) (
    // clock and reset
    input  wire clk,
    input  wire reset_n,
    // sampling
    input  wire tick,
    input  wire invert,
    input  wire din,
    // results
    output reg  level,
    output wire rise,
    output wire fall
);
    reg syncA;
    reg syncB;
    reg prevLevel;
    reg strobe;
    wire adjusted;

    // two-flop synchroniser for pins
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA <= 1'b0;
            syncB <= 1'b0;
        end else begin
            syncA <= din;
            syncB <= syncA;
        end
    end

    assign adjusted = ((SYNC != 0) ? syncB : din) ^ invert;

    // samples taken only on control-cycle ticks
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level     <= 1'b0;
            prevLevel <= 1'b0;
            strobe    <= 1'b0;
        end else begin
            strobe <= tick;
            if (tick) begin
                prevLevel <= level;
                level     <= adjusted;
            end
        end
    end

    // compare successive samples
    assign rise = strobe & level & ~prevLevel;
    assign fall = strobe & ~level & prevLevel;
endmodule // cfsl_edge_sampler

`default_nettype wire

/* File: src/cfsl_counter_select.v */
// counter channel with selectable auxiliary function and latches
//
// Contract
// - five auxiliary functions, at most one active per selection field (codes 5 to 7 select none).
// - latch/disable/sample use start OR input; preset modes input only.
// - function input polarity selectable, positive logic by default.
// - sampling period set in 10 ms steps, 10 ms to 655350 ms.
// - software start sampled on the 1 ms control cycle.
// - latch mode, trigger rising edge copies count to latch area one.
// - latch pin rising edge copies count to latch area two always.
// - latching happens whether or not counting is enabled.
// - pin triggers pass filter; latch area update waits a further 1 ms.
// - trigger sources ORed then edge detected; second source adds nothing.
// - count disable mode holds count while trigger asserted.
// - sampling counts pulses only within period after trigger.
// - latch/preset mode latches on rise, presets on fall of input.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "cfsl_map.vh"

module cfsl_counter_select #(
    parameter TICK_CYCLES = `CFSL_TICK_CYCLES,
    parameter UNIT_TICKS  = `CFSL_SAMPLE_UNIT_TICKS
) (
    // clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // pins
    input  wire        pulseIn,
    input  wire        functionIn,
    input  wire        latchIn,
    // status outputs
    output reg  [31:0] countValue,
    output reg  [31:0] latchValue1,
    output reg  [31:0] latchValue2
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    // registers
    reg [31:0] ctrlReg;
    reg [15:0] sampleTime;
    reg [31:0] presetValue;
    reg [31:0] sampleCount;
    reg [1:0]  sampleState;
    reg [19:0] sampleTimer;
    reg [31:0] tickCount;
    reg        tick;
    reg        trigPrev;
    reg        trigStrobe;
    reg        holdFlag;
    reg        latch1Pend;
    reg        latch2Pend;
    reg [31:0] latch1Hold;
    reg [31:0] latch2Hold;
    reg        pulseA;
    reg        pulseB;
    reg        pulsePrev;

    wire       countEnable = ctrlReg[`CFSL_CTRL_COUNT_EN];
    wire       negLogic    = ctrlReg[`CFSL_CTRL_NEG_LOGIC];
    wire [2:0] fnSel = ctrlReg[`CFSL_CTRL_FSEL_HI:`CFSL_CTRL_FSEL_LO];
    wire       startLevel;
    wire       funcLevel;
    wire       funcRise;
    wire       funcFall;
    wire       latchRise;
    wire       inputOnly;
    wire       trigLevel;
    wire       trigRise;
    wire       pulseRise;
    wire       apbWrite;
    wire       apbRead;
    wire       addrHit;
    wire [19:0] sampleTicks;

    // control cycle tick generator
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tickCount <= 32'h0000_0000;
            tick      <= 1'b0;
        end else if (tickCount == TICK_CYCLES - 1) begin
            tickCount <= 32'h0000_0000;
            tick      <= 1'b1;
        end else begin
            tickCount <= tickCount + 32'h0000_0001;
            tick      <= 1'b0;
        end
    end

    // software start sampled each control cycle
    cfsl_edge_sampler #(.SYNC(0)) uStart (
        .clk     (clk),
        .reset_n (reset_n),
        .tick    (tick),
        .invert  (1'b0),
        .din     (ctrlReg[`CFSL_CTRL_START]),
        .level   (startLevel),
        .rise    (),
        .fall    ()
    );

    // function input pin with selectable polarity
    cfsl_edge_sampler #(.SYNC(1)) uFunc (
        .clk     (clk),
        .reset_n (reset_n),
        .tick    (tick),
        .invert  (negLogic),
        .din     (functionIn),
        .level   (funcLevel),
        .rise    (funcRise),
        .fall    (funcFall)
    );

    // dedicated latch pin
    cfsl_edge_sampler #(.SYNC(1)) uLatch (
        .clk     (clk),
        .reset_n (reset_n),
        .tick    (tick),
        .invert  (1'b0),
        .din     (latchIn),
        .level   (),
        .rise    (latchRise),
        .fall    ()
    );

    // preset modes see only the pin, others the OR of both
    assign inputOnly = (fnSel == `CFSL_FN_DIS_PRESET) ||
                       (fnSel == `CFSL_FN_LATCH_PRESET);
    assign trigLevel = inputOnly ? funcLevel
                                 : (startLevel | funcLevel);

    // edge of the combined trigger
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trigPrev   <= 1'b0;
            trigStrobe <= 1'b0;
        end else begin
            trigStrobe <= tick;
            if (trigStrobe) begin
                trigPrev <= trigLevel;
            end
        end
    end
    assign trigRise = trigStrobe & trigLevel & ~trigPrev;

    // counting pulse pin synchroniser and edge
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulseA    <= 1'b0;
            pulseB    <= 1'b0;
            pulsePrev <= 1'b0;
        end else begin
            pulseA    <= pulseIn;
            pulseB    <= pulseA;
            pulsePrev <= pulseB;
        end
    end
    assign pulseRise = pulseB & ~pulsePrev;

    // count disable hold, per selected function
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            holdFlag <= 1'b0;
        end else begin
            case (fnSel)
                `CFSL_FN_DISABLE: begin
                    holdFlag <= trigLevel;
                end
                `CFSL_FN_DIS_PRESET: begin
                    if (funcRise) begin
                        holdFlag <= 1'b1;
                    end else if (funcFall) begin
                        holdFlag <= 1'b0;
                    end
                end
                default: begin
                    holdFlag <= 1'b0;
                end
            endcase
        end
    end

    // current count with preset on input fall in preset modes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            countValue <= 32'h0000_0000;
        end else if (inputOnly && funcFall) begin
            countValue <= presetValue;
        end else if (pulseRise && countEnable && !holdFlag &&
                     !(fnSel == `CFSL_FN_DISABLE && trigLevel)) begin
            countValue <= countValue + 32'h0000_0001;
        end
    end

    // latch capture, area update one control cycle later
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latch1Pend  <= 1'b0;
            latch2Pend  <= 1'b0;
            latch1Hold  <= 32'h0000_0000;
            latch2Hold  <= 32'h0000_0000;
            latchValue1 <= 32'h0000_0000;
            latchValue2 <= 32'h0000_0000;
        end else begin
            if (trigRise && (fnSel == `CFSL_FN_LATCH ||
                             fnSel == `CFSL_FN_LATCH_PRESET)) begin
                latch1Pend <= 1'b1;
                latch1Hold <= countValue;
            end else if (tick && latch1Pend) begin
                latch1Pend  <= 1'b0;
                latchValue1 <= latch1Hold;
            end
            if (latchRise) begin
                latch2Pend <= 1'b1;
                latch2Hold <= countValue;
            end else if (tick && latch2Pend) begin
                latch2Pend  <= 1'b0;
                latchValue2 <= latch2Hold;
            end
        end
    end

    // sampling window length in control cycles
    assign sampleTicks = {4'h0, sampleTime} *
                         {16'h0000, UNIT_TICKS[3:0]};

    // sampling counter state machine
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sampleState <= ST_IDLE;
            sampleTimer <= 20'h0_0000;
            sampleCount <= 32'h0000_0000;
        end else begin
            case (sampleState)
                ST_IDLE: begin
                    if (fnSel == `CFSL_FN_SAMPLE && trigRise) begin
                        sampleState <= ST_RUN;
                        sampleTimer <= sampleTicks;
                        sampleCount <= 32'h0000_0000;
                    end
                end
                ST_RUN: begin
                    if (fnSel != `CFSL_FN_SAMPLE) begin
                        sampleState <= ST_IDLE;
                    end else if (tick && sampleTimer <= 20'h0_0001) begin
                        sampleState <= ST_IDLE;
                        sampleTimer <= 20'h0_0000;
                    end else begin
                        if (tick) begin
                            sampleTimer <= sampleTimer - 20'h0_0001;
                        end
                        if (trigRise) begin
                            sampleCount <= 32'h0000_0000;
                        end else if (pulseRise) begin
                            sampleCount <= sampleCount + 32'h0000_0001;
                        end
                    end
                end
                default: begin
                    sampleState <= ST_IDLE;
                end
            endcase
        end
    end

    // apb decode, zero wait states
    assign pready   = 1'b1;
    assign apbWrite = psel & penable & pwrite;
    assign apbRead  = psel & ~pwrite;
    assign addrHit  = (paddr[1:0] == 2'b00) && (paddr <= `CFSL_OFS_STATUS);
    assign pslverr  = psel & penable & ~addrHit;

    // software writable registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrlReg     <= `CFSL_RST_CTRL;
            sampleTime  <= `CFSL_RST_SAMPLE_TIME;
            presetValue <= `CFSL_RST_PRESET;
        end else if (apbWrite) begin
            case (paddr)
                `CFSL_OFS_CTRL: begin
                    ctrlReg <= pwdata & 32'h0000_0077;
                end
                `CFSL_OFS_SAMPLE_TIME: begin
                    if (pwdata[15:0] != 16'h0000) begin
                        sampleTime <= pwdata[15:0];
                    end
                end
                `CFSL_OFS_PRESET: begin
                    presetValue <= pwdata;
                end
                default: begin
                    presetValue <= presetValue;
                end
            endcase
        end
    end

    // read data registered in the setup cycle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (apbRead) begin
            case (paddr)
                `CFSL_OFS_CTRL:        prdata <= ctrlReg;
                `CFSL_OFS_SAMPLE_TIME: prdata <= {16'h0000, sampleTime};
                `CFSL_OFS_PRESET:      prdata <= presetValue;
                `CFSL_OFS_COUNT:       prdata <= countValue;
                `CFSL_OFS_LATCH1:      prdata <= latchValue1;
                `CFSL_OFS_LATCH2:      prdata <= latchValue2;
                `CFSL_OFS_SAMPLE_CNT:  prdata <= sampleCount;
                `CFSL_OFS_STATUS: begin
                    prdata <= {28'h000_0000, latch2Pend, latch1Pend,
                               holdFlag, sampleState[1]};
                end
                default:               prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // cfsl_counter_select

`default_nettype wire

/* File: tb/cfsl_monitor.sv */
// checker for apb answers, readback and capture timing
`timescale 1ns/10ps
`default_nettype none
`include "cfsl_map.vh"
module cfsl_monitor #(
    parameter TICK_CYCLES = `CFSL_TICK_CYCLES
) (
    // clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and values
    input wire logic        pulseIn,
    input wire logic        functionIn,
    input wire logic        latchIn,
    input wire logic [31:0] countValue,
    input wire logic [31:0] latchValue1,
    input wire logic [31:0] latchValue2
);
    localparam int LIM = 3 * TICK_CYCLES + 6;
    logic [15:0] sinceLatch;
    logic [3:0]  sincePulse;
    logic        latchOld;
    logic        pulseOld;
    logic        rdAcc;
    logic [31:0] presetSeen;
    assign rdAcc = psel && penable && !pwrite;
    // preset value as last written over the bus
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            presetSeen <= 32'h0000_0000;
        else if (psel && penable && pwrite && paddr == `CFSL_OFS_PRESET)
            presetSeen <= pwdata;
    end
    // cycles since the last rise of the latch and pulse pins, saturating
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sinceLatch <= 16'hffff;
            sincePulse <= 4'hf;
            latchOld   <= 1'b0;
            pulseOld   <= 1'b0;
        end else begin
            latchOld <= latchIn;
            pulseOld <= pulseIn;
            if (latchIn && !latchOld)
                sinceLatch <= 16'h0000;
            else if (sinceLatch != 16'hffff)
                sinceLatch <= sinceLatch + 16'h0001;
            if (pulseIn && !pulseOld)
                sincePulse <= 4'h0;
            else if (sincePulse != 4'hf)
                sincePulse <= sincePulse + 4'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_decode: assert property (psel && penable |->
        pslverr == (paddr > 8'h1c || paddr[1:0] != 2'h0))
        else $error("pslverr wrong for address");
    a_err_idle: assert property (!penable |-> !pslverr)
        else $error("pslverr outside access");
    a_bad_zero: assert property (rdAcc && pslverr |-> prdata == 0)
        else $error("refused read not zero");
    a_rd_count: assert property (rdAcc && paddr == `CFSL_OFS_COUNT
        |-> prdata == $past(countValue)) else $error("count read wrong");
    a_rd_first: assert property (rdAcc && paddr == `CFSL_OFS_LATCH1
        |-> prdata == $past(latchValue1)) else $error("latch1 read wrong");
    a_rd_second: assert property (rdAcc && paddr == `CFSL_OFS_LATCH2
        |-> prdata == $past(latchValue2)) else $error("latch2 read wrong");
    a_latch_cause: assert property ($changed(latchValue2)
        |-> sinceLatch <= LIM) else $error("latch2 moved without pin");
    a_count_pulse: assert property
        (countValue == $past(countValue) + 1 |-> sincePulse <= 4'h6)
        else $error("count stepped without pulse");
    a_count_jump: assert property ($changed(countValue) &&
        countValue != $past(countValue) + 1 |-> countValue == presetSeen)
        else $error("count jumped to a value other than preset");
    c_latch2: cover property ($changed(latchValue2));
    c_latch1: cover property ($changed(latchValue1));
    c_refuse: cover property (pslverr);
endmodule // cfsl_monitor
bind cfsl_counter_select cfsl_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulseIn(pulseIn),
    .functionIn(functionIn), .latchIn(latchIn), .countValue(countValue),
    .latchValue1(latchValue1), .latchValue2(latchValue2));
`default_nettype wire

/* File: tb/cfsl_pin_source.sv */
// pulse source and trigger pins standing on the field side
`timescale 1ns/10ps
`default_nettype none
module cfsl_pin_source #(
    parameter int HALF = 4,
    parameter int LAG  = 3
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // requests
    input  wire logic       go,
    input  wire logic [7:0] num,
    input  wire logic       funcReq,
    input  wire logic       latchReq,
    // pins
    output logic            pulseIn,
    output logic            functionIn,
    output logic            latchIn
);
    logic [7:0]     left;
    logic [7:0]     phase;
    logic [LAG-1:0] funcDly = '0;
    logic [LAG-1:0] latchDly = '0;
    // trigger pins follow requests after a response lag
    assign functionIn = funcDly[LAG-1];
    assign latchIn    = latchDly[LAG-1];
    always @(posedge clk) begin
        funcDly  <= {funcDly[LAG-2:0], funcReq};
        latchDly <= {latchDly[LAG-2:0], latchReq};
    end
    // burst of num pulses, low then high for HALF clocks each
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            left    <= 8'h00;
            phase   <= 8'h00;
            pulseIn <= 1'b0;
        end else if (go) begin
            left  <= num;
            phase <= 8'h00;
        end else if (left != 8'h00) begin
            phase   <= phase + 8'h01;
            pulseIn <= (phase >= HALF);
            if (phase == 2 * HALF - 1) begin
                phase <= 8'h00;
                left  <= left - 8'h01;
            end
        end else begin
            pulseIn <= 1'b0;
        end
    end
endmodule // cfsl_pin_source
`default_nettype wire

/* File: tb/cfsl_counter_select_test.sv */
// self-checking bench for the counter function channel
`timescale 1ns/10ps
`default_nettype none
`include "cfsl_map.vh"
module cfsl_counter_select_test;
    localparam int TICK = 8;
    localparam int WT   = 5 * TICK;
    localparam logic [7:0] CT = `CFSL_OFS_CTRL;
    localparam logic [7:0] ST = `CFSL_OFS_SAMPLE_TIME;
    logic clk = 1'b0, reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, countValue, latchValue1, latchValue2, rd, sc;
    logic pready, pslverr, pulseIn, functionIn, latchIn, er;
    logic go = 1'b0, funcReq = 1'b0, latchReq = 1'b0;
    logic [7:0] num = 8'h00;
    int fails = 0, compares = 0;
    cfsl_counter_select #(.TICK_CYCLES(TICK), .UNIT_TICKS(4)) uut (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pulseIn(pulseIn),
        .functionIn(functionIn), .latchIn(latchIn), .countValue(countValue),
        .latchValue1(latchValue1), .latchValue2(latchValue2));
    cfsl_pin_source src (.clk(clk), .reset_n(reset_n), .go(go), .num(num),
        .funcReq(funcReq), .latchReq(latchReq), .pulseIn(pulseIn),
        .functionIn(functionIn), .latchIn(latchIn));
    // 10 MHz clock
    always #50 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer, answer taken where pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic ctl(input logic [2:0] f, input logic n, s, e);
        apb(1'b1, CT, {25'h000_0000, f, 1'b0, n, s, e});
    endtask
    task automatic launch(input logic [7:0] n);
        @(posedge clk);
        num <= n;
        go  <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic pulses(input logic [7:0] n);
        launch(n);
        cyc(8 * n + 8);
    endtask
    task automatic t_regs;
        rdc(CT, `CFSL_RST_CTRL);
        rdc(ST, 32'h0000_0001);
        rdc(`CFSL_OFS_PRESET, `CFSL_RST_PRESET);
        apb(1'b1, ST, 32'h0000_0000);
        rdc(ST, 32'h0000_0001);
        apb(1'b1, ST, 32'h0000_ffff);
        rdc(ST, 32'h0000_ffff);
        apb(1'b1, `CFSL_OFS_COUNT, 32'h0000_0005);
        rdc(`CFSL_OFS_COUNT, 32'h0000_0000);
        rdc(8'h20, 32'h0000_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b1, ST, 32'h0000_0001);
    endtask
    task automatic t_count;
        ctl(`CFSL_FN_LATCH, 1'b0, 1'b0, 1'b1);
        pulses(5);
        rdc(`CFSL_OFS_COUNT, 32'h0000_0005);
        ctl(`CFSL_FN_LATCH, 1'b0, 1'b0, 1'b0);
        pulses(3);
        chk(countValue, 32'h0000_0005);
    endtask
    task automatic t_soft;
        ctl(`CFSL_FN_LATCH, 1'b0, 1'b1, 1'b0);
        cyc(WT);
        chk(latchValue1, 32'h0000_0005);
        ctl(`CFSL_FN_LATCH, 1'b0, 1'b1, 1'b1);
        pulses(2);
        funcReq <= 1'b1;
        cyc(WT);
        chk(latchValue1, 32'h0000_0005);
        funcReq <= 1'b0;
        ctl(`CFSL_FN_LATCH, 1'b0, 1'b0, 1'b1);
        cyc(WT);
        funcReq <= 1'b1;
        cyc(WT);
        chk(latchValue1, 32'h0000_0007);
        funcReq <= 1'b0;
    endtask
    task automatic t_pin;
        pulses(1);
        ctl(`CFSL_FN_LATCH, 1'b0, 1'b0, 1'b0);
        latchReq <= 1'b1;
        cyc(WT);
        chk(latchValue2, 32'h0000_0008);
        chk(latchValue1, 32'h0000_0007);
        rdc(`CFSL_OFS_LATCH2, 32'h0000_0008);
        latchReq <= 1'b0;
    endtask
    task automatic t_neg;
        funcReq <= 1'b1;
        cyc(WT);
        ctl(`CFSL_FN_LATCH, 1'b1, 1'b0, 1'b1);
        pulses(1);
        funcReq <= 1'b0;
        cyc(WT);
        chk(latchValue1, 32'h0000_0009);
        ctl(`CFSL_FN_LATCH, 1'b0, 1'b0, 1'b1);
        cyc(WT);
    endtask
    task automatic t_hold;
        ctl(`CFSL_FN_DISABLE, 1'b0, 1'b0, 1'b1);
        funcReq <= 1'b1;
        cyc(WT);
        pulses(3);
        chk(countValue, 32'h0000_0009);
        funcReq <= 1'b0;
        cyc(WT);
        pulses(2);
        chk(countValue, 32'h0000_000b);
        ctl(`CFSL_FN_DISABLE, 1'b0, 1'b1, 1'b1);
        cyc(WT);
        pulses(2);
        chk(countValue, 32'h0000_000b);
        rdc(`CFSL_OFS_STATUS, 32'h0000_0002);
    endtask
    task automatic t_sample;
        ctl(`CFSL_FN_SAMPLE, 1'b0, 1'b0, 1'b0);
        launch(40);
        cyc(WT);
        ctl(`CFSL_FN_SAMPLE, 1'b0, 1'b1, 1'b0);
        cyc(2 * TICK);
        rdc(`CFSL_OFS_STATUS, 32'h0000_0001);
        cyc(6 * TICK);
        apb(1'b0, `CFSL_OFS_SAMPLE_CNT, 32'h0000_0000);
        sc = rd;
        chk({31'h0, sc >= 3 && sc <= 5}, 32'h0000_0001);
        cyc(WT);
        rdc(`CFSL_OFS_SAMPLE_CNT, sc);
        rdc(`CFSL_OFS_STATUS, 32'h0000_0000);
        cyc(200);
    endtask
    task automatic t_preset;
        apb(1'b1, `CFSL_OFS_PRESET, 32'h1234_5678);
        ctl(`CFSL_FN_DIS_PRESET, 1'b0, 1'b1, 1'b1);
        cyc(WT);
        pulses(2);
        chk(countValue, 32'h0000_000d);
        funcReq <= 1'b1;
        cyc(WT);
        pulses(2);
        chk(countValue, 32'h0000_000d);
        funcReq <= 1'b0;
        cyc(WT);
        chk(countValue, 32'h1234_5678);
        ctl(`CFSL_FN_LATCH_PRESET, 1'b0, 1'b0, 1'b1);
        pulses(1);
        funcReq <= 1'b1;
        cyc(WT);
        chk(latchValue1, 32'h1234_5679);
        funcReq <= 1'b0;
        cyc(WT);
        chk(countValue, 32'h1234_5678);
    endtask
    task automatic conclude;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(10);
        reset_n <= 1'b1;
        t_regs;
        t_count;
        t_soft;
        t_pin;
        t_neg;
        t_hold;
        t_sample;
        t_preset;
        conclude;
    end
    // watchdog
    initial begin
        cyc(20000);
        fails++;
        conclude;
    end
endmodule // cfsl_counter_select_test
`default_nettype wire
